// ---- src/tcc_consts.svh ----
// Constants for the timer capture and compare block.
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// Byte location codes on the CPU port.
`define TCC_LOC_CNT_L 3'h0
`define TCC_LOC_CNT_H 3'h1
`define TCC_LOC_CAP_L 3'h2
`define TCC_LOC_CAP_H 3'h3
`define TCC_LOC_CMPA_L 3'h4
`define TCC_LOC_CMPA_H 3'h5
`define TCC_LOC_CMPB_L 3'h6
`define TCC_LOC_CMPB_H 3'h7

// Waveform mode codes that matter to this block.
`define TCC_MODE_NORMAL 4'h0
`define TCC_MODE_CTC_CMP 4'h4
`define TCC_MODE_CTC_CAP 4'hC
`define TCC_MODE_RSVD 4'hD
`define TCC_MODE_PWM_PC_CAP 4'h8
`define TCC_MODE_PWM_PH_CAP 4'hA
`define TCC_MODE_PWM_FAST_CAP 4'hE

// Output action codes.
`define TCC_ACT_NONE 2'h0
`define TCC_ACT_TOGGLE 2'h1
`define TCC_ACT_CLEAR 2'h2
`define TCC_ACT_SET 2'h3

// Reset values and filter length.
`define TCC_RST_WORD 16'h0000
`define TCC_RST_BYTE 8'h00
`define TCC_FILT_SAMPLES 4

`endif

// ---- src/tcc_pkg.sv ----
// Types shared by the timer capture and compare block.
package tcc_pkg;

    typedef struct packed {
        logic cap_sync1;
        logic cap_sync2;
        logic cmp_sync1;
        logic cmp_sync2;
        logic edge_prev;
        logic [15:0] capture_reg;
        logic capture_flag;
        logic [7:0] temp;
        logic [7:0] rdata;
        logic [1:0][15:0] buf_val;
        logic [1:0][15:0] act_val;
        logic [1:0] compare_flag;
        logic [1:0] compare_output;
        logic block;
        logic counter_write;
        logic [15:0] counter_wdata;
    } tcc_state_t;

endpackage

// ---- src/tcc_noise_filter.sv ----
// Noise filter that passes a level once it has been stable for a set number of samples.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_consts.svh"

module tcc_noise_filter #(
    parameter int SAMPLES = `TCC_FILT_SAMPLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Level in and filtered level out
    input wire logic level_in,
    output logic level_out
);
    typedef struct packed {
        logic [SAMPLES-1:0] hist;
        logic out;
    } tcc_filt_state_t;

    tcc_filt_state_t state_reg;
    tcc_filt_state_t state_next;
    logic [SAMPLES-1:0] hist_new;
    logic all_high;
    logic all_low;

    // The newest sample is one of the four, so the delay is exactly four cycles.
    assign hist_new = {state_reg.hist[SAMPLES-2:0], level_in};
    assign all_high = &hist_new;
    assign all_low = ~|hist_new;

    always_comb begin
        state_next = state_reg;
        state_next.hist = hist_new;
        // The output only moves when every stored sample agrees.
        if (all_high) begin
            state_next.out = 1'b1;
        end else if (all_low) begin
            state_next.out = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign level_out = state_reg.out;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    chk_filt_change_agree: assert property ($changed(level_out) |-> $past(all_high || all_low))
        else $error("Filter output changed without agreeing samples.");
    chk_filt_settle_four: assert property ((level_in && !level_out) [*4] |=> level_out)
        else $error("Filter did not follow a steady high input.");

endmodule
`default_nettype wire

// ---- src/tcc_top.sv ----
// Input capture and output compare logic of a 16-bit timer.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_consts.svh"

module tcc_top
    import tcc_pkg::*;
#(
    parameter int CHANNELS = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // CPU byte port
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [2:0] cpu_loc,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    // Counter unit
    input wire logic [15:0] counter_value,
    input wire logic timer_tick,
    input wire logic buffer_load,
    output logic counter_write,
    output logic [15:0] counter_wdata,
    // Configuration
    input wire logic [3:0] waveform_mode_select,
    input wire logic comparator_capture_select,
    input wire logic capture_filter_enable,
    input wire logic capture_edge_select,
    input wire logic capture_irq_enable,
    input wire logic [1:0] compare_irq_enable,
    input wire logic [1:0] output_action_select_a,
    input wire logic [1:0] output_action_select_b,
    input wire logic [1:0] force_match_strobe,
    // Flag clearing
    input wire logic capture_flag_clear,
    input wire logic capture_irq_ack,
    input wire logic [1:0] compare_flag_clear,
    input wire logic [1:0] compare_irq_ack,
    // Event sources
    input wire logic capture_input_pin,
    input wire logic comparator_output,
    // Status and events
    output logic capture_flag,
    output logic capture_irq,
    output logic [1:0] compare_flag,
    output logic [1:0] compare_irq,
    output logic [1:0] compare_match,
    output logic [1:0] compare_output,
    output logic [15:0] capture_register,
    output logic [15:0] compare_value_a,
    output logic [15:0] compare_value_b,
    output logic compare_top_a
);
    tcc_state_t state_reg;
    tcc_state_t state_next;
    logic pwm_mode;
    logic cap_top_mode;
    logic src_level;
    logic filt_level;
    logic cap_level;
    logic capture_trig;
    logic [1:0] match_raw;
    logic [1:0][1:0] action;

    // Modes 0, 4, 12 and the reserved 13 are the only non-PWM codes.
    assign pwm_mode = !(waveform_mode_select == `TCC_MODE_NORMAL
        || waveform_mode_select == `TCC_MODE_CTC_CMP
        || waveform_mode_select == `TCC_MODE_CTC_CAP
        || waveform_mode_select == `TCC_MODE_RSVD);
    assign cap_top_mode = waveform_mode_select == `TCC_MODE_PWM_PC_CAP
        || waveform_mode_select == `TCC_MODE_PWM_PH_CAP
        || waveform_mode_select == `TCC_MODE_CTC_CAP
        || waveform_mode_select == `TCC_MODE_PWM_FAST_CAP;

    // Both sources are synchronised first, so switching the selector can
    // itself look like an edge; software clears the flag after a change.
    assign src_level = comparator_capture_select ? state_reg.cmp_sync2 : state_reg.cap_sync2;

    // The filter runs on every system clock regardless of the prescaler.
    tcc_noise_filter #(
        .SAMPLES(`TCC_FILT_SAMPLES)
    ) u_filter (
        .clk(clk),
        .arst_n(arst_n),
        .level_in(src_level),
        .level_out(filt_level)
    );

    assign cap_level = capture_filter_enable ? filt_level : src_level;
    assign capture_trig = !cap_top_mode
        && (cap_level != state_reg.edge_prev)
        && (cap_level == capture_edge_select);

    assign action[0] = output_action_select_a;
    assign action[1] = output_action_select_b;

    function automatic logic apply_action(input logic cur, input logic [1:0] act);
        logic res;
        res = cur;
        unique case (act)
            `TCC_ACT_NONE: res = cur;
            `TCC_ACT_TOGGLE: res = !cur;
            `TCC_ACT_CLEAR: res = 1'b0;
            `TCC_ACT_SET: res = 1'b1;
        endcase
        return res;
    endfunction

    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            match_raw[i] = counter_value == state_reg.act_val[i];
            // A counter write just before the tick hides this tick's match.
            compare_match[i] = timer_tick && match_raw[i] && !state_reg.block;
        end
    end

    always_comb begin
        state_next = state_reg;
        state_next.cap_sync1 = capture_input_pin;
        state_next.cap_sync2 = state_reg.cap_sync1;
        state_next.cmp_sync1 = comparator_output;
        state_next.cmp_sync2 = state_reg.cmp_sync1;
        state_next.edge_prev = cap_level;
        state_next.counter_write = 1'b0;

        // Capture flag: a new capture wins over a clear in the same cycle.
        if (capture_flag_clear || capture_irq_ack) begin
            state_next.capture_flag = 1'b0;
        end
        if (capture_trig) begin
            state_next.capture_reg = counter_value;
            state_next.capture_flag = 1'b1;
        end

        // The block lasts until the next timer tick, even if that is far off.
        if (timer_tick) begin
            state_next.block = 1'b0;
        end

        for (int i = 0; i < CHANNELS; i++) begin
            if (compare_flag_clear[i] || compare_irq_ack[i]) begin
                state_next.compare_flag[i] = 1'b0;
            end
            if (compare_match[i]) begin
                state_next.compare_flag[i] = 1'b1;
            end
            if (!pwm_mode && (compare_match[i] || force_match_strobe[i])) begin
                state_next.compare_output[i] = apply_action(state_reg.compare_output[i],
                    action[i]);
            end
            if (pwm_mode && buffer_load) begin
                state_next.act_val[i] = state_reg.buf_val[i];
            end
        end

        if (cpu_rd) begin
            unique case (cpu_loc)
                `TCC_LOC_CNT_L: begin
                    state_next.rdata = counter_value[7:0];
                    state_next.temp = counter_value[15:8];
                end
                `TCC_LOC_CAP_L: begin
                    state_next.rdata = state_reg.capture_reg[7:0];
                    state_next.temp = state_reg.capture_reg[15:8];
                end
                `TCC_LOC_CNT_H, `TCC_LOC_CAP_H: state_next.rdata = state_reg.temp;
                `TCC_LOC_CMPA_L: state_next.rdata = state_reg.buf_val[0][7:0];
                `TCC_LOC_CMPA_H: state_next.rdata = state_reg.buf_val[0][15:8];
                `TCC_LOC_CMPB_L: state_next.rdata = state_reg.buf_val[1][7:0];
                `TCC_LOC_CMPB_H: state_next.rdata = state_reg.buf_val[1][15:8];
            endcase
        end

        if (cpu_wr) begin
            unique case (cpu_loc)
                `TCC_LOC_CNT_H, `TCC_LOC_CAP_H, `TCC_LOC_CMPA_H, `TCC_LOC_CMPB_H: begin
                    state_next.temp = cpu_wdata;
                end
                `TCC_LOC_CNT_L: begin
                    state_next.counter_write = 1'b1;
                    state_next.counter_wdata = {state_reg.temp, cpu_wdata};
                    state_next.block = 1'b1;
                end
                `TCC_LOC_CAP_L: begin
                    if (cap_top_mode) begin
                        state_next.capture_reg = {state_reg.temp, cpu_wdata};
                    end
                end
                `TCC_LOC_CMPA_L, `TCC_LOC_CMPB_L: begin
                    // Both bytes land together so the compare never sees half a word.
                    state_next.buf_val[cpu_loc[1]] = {state_reg.temp, cpu_wdata};
                    if (!pwm_mode) begin
                        state_next.act_val[cpu_loc[1]] = {state_reg.temp, cpu_wdata};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign cpu_rdata = state_reg.rdata;
    assign counter_write = state_reg.counter_write;
    assign counter_wdata = state_reg.counter_wdata;
    assign capture_flag = state_reg.capture_flag;
    assign capture_irq = state_reg.capture_flag && capture_irq_enable;
    assign compare_flag = state_reg.compare_flag;
    assign compare_irq = state_reg.compare_flag & compare_irq_enable;
    assign compare_output = state_reg.compare_output;
    assign capture_register = state_reg.capture_reg;
    assign compare_value_a = state_reg.act_val[0];
    assign compare_value_b = state_reg.act_val[1];
    // Channel A can serve the counter as its top value.
    assign compare_top_a = timer_tick && match_raw[0];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_cnt_write;
        cpu_wr && cpu_loc == `TCC_LOC_CNT_L;
    endsequence

    sequence s_cmpa_write;
        cpu_wr && cpu_loc == `TCC_LOC_CMPA_L;
    endsequence

    chk_capture_copy: assert property (capture_trig |=>
        capture_register == $past(counter_value) && capture_flag)
        else $error("Capture did not copy the counter and set the flag.");
    chk_capture_irq_req: assert property ((capture_flag && capture_irq_enable) |-> capture_irq)
        else $error("Capture interrupt not requested.");
    chk_capture_clear: assert property ((capture_irq_ack && !capture_trig) |=> !capture_flag)
        else $error("Capture flag not cleared on service.");
    chk_read_holding: assert property ((cpu_rd && cpu_loc == `TCC_LOC_CAP_L)
        ##1 (cpu_rd && cpu_loc == `TCC_LOC_CAP_H) |=> cpu_rdata == $past(capture_register[15:8], 2))
        else $error("High byte read did not return the held byte.");
    chk_cap_write_guard: assert property ((cpu_wr && cpu_loc == `TCC_LOC_CAP_L
        && !cap_top_mode && !capture_trig) |=> $stable(capture_register))
        else $error("Capture register written outside capture-top modes.");
    chk_cap_top_quiet: assert property (cap_top_mode |-> !capture_trig)
        else $error("Capture fired in a capture-top mode.");
    chk_match_flag: assert property ((timer_tick && match_raw[1] && !state_reg.block)
        |=> compare_flag[1])
        else $error("Compare match did not set the flag.");
    chk_match_block: assert property (s_cnt_write ##1 timer_tick |-> compare_match == 2'h0)
        else $error("Compare match not blocked after counter write.");
    chk_cmp_direct: assert property ((s_cmpa_write and !pwm_mode) |=>
        compare_value_a == {$past(state_reg.temp), $past(cpu_wdata)})
        else $error("Compare word not written in one step.");
    chk_cmp_buffered: assert property ((s_cmpa_write and (pwm_mode && !buffer_load)) |=>
        $stable(compare_value_a))
        else $error("Buffered compare value reached the comparator early.");
    chk_force_set: assert property ((force_match_strobe[0] && !pwm_mode
        && output_action_select_a == `TCC_ACT_SET) |=> compare_output[0])
        else $error("Forced match did not apply the set action.");
    chk_cmp_irq_req: assert property (compare_flag[0] && compare_irq_enable[0] |-> compare_irq[0])
        else $error("Compare interrupt not requested.");

    // A reader may leave an idle cycle between the two bytes of a word.
    sequence s_cap_low_read;
        cpu_rd && cpu_loc == `TCC_LOC_CAP_L;
    endsequence

    sequence s_cap_high_read;
        cpu_rd && cpu_loc == `TCC_LOC_CAP_H;
    endsequence

    chk_read_gap_holding: assert property (s_cap_low_read ##1 (!cpu_rd && !cpu_wr)
        ##1 s_cap_high_read |=> cpu_rdata == $past(capture_register[15:8], 3))
        else $error("Late high byte read lost the held byte.");
    chk_match_block_late: assert property (s_cnt_write ##1 !timer_tick ##1 timer_tick |-> compare_match == 2'h0)
        else $error("Match not blocked at the first tick.");
    chk_match_flag_a: assert property ((timer_tick && match_raw[0] && !state_reg.block)
        |=> compare_flag[0])
        else $error("Channel A match did not set the flag.");
    chk_cmp_clear: assert property ((compare_irq_ack[0] && !compare_match[0]) |=> !compare_flag[0])
        else $error("Compare flag not cleared on service.");
    chk_capture_set_wins: assert property ((capture_trig
        && (capture_flag_clear || capture_irq_ack)) |=> capture_flag)
        else $error("A clear hid a new capture.");
    chk_cmp_read_direct: assert property ((cpu_rd && cpu_loc == `TCC_LOC_CMPB_H)
        |=> $stable(state_reg.temp))
        else $error("Compare read disturbed the holding byte.");
    chk_cnt_write_pulse: assert property (s_cnt_write |=> counter_write
        && counter_wdata == {$past(state_reg.temp), $past(cpu_wdata)})
        else $error("Counter load word not built from the holding byte.");
    chk_cap_top_write: assert property ((cpu_wr && cpu_loc == `TCC_LOC_CAP_L && cap_top_mode)
        |=> capture_register == {$past(state_reg.temp), $past(cpu_wdata)})
        else $error("Capture register not written in a capture-top mode.");
    chk_buffer_move: assert property ((pwm_mode && buffer_load && !cpu_wr)
        |=> compare_value_b == $past(state_reg.buf_val[1]))
        else $error("Buffered compare value not moved at the load pulse.");
    chk_cmp_irq_off: assert property (!compare_irq_enable[1] |-> !compare_irq[1])
        else $error("Disabled compare interrupt requested.");
    // A forced match may move the output but never a flag.
    chk_force_set_b: assert property ((force_match_strobe[1] && !pwm_mode
        && output_action_select_b == `TCC_ACT_SET) |=> compare_output[1])
        else $error("Forced match on B did not set the output.");
    chk_force_toggle_b: assert property ((force_match_strobe[1] && !pwm_mode && !compare_match[1]
        && output_action_select_b == `TCC_ACT_TOGGLE) |=> compare_output[1] != $past(compare_output[1]))
        else $error("Forced match on B did not toggle the output.");
    chk_force_no_flag: assert property ((force_match_strobe != 2'h0 && compare_match == 2'h0
        && compare_flag == 2'h0) |=> compare_flag == 2'h0)
        else $error("Forced match set a compare flag.");
    chk_pwm_out_hold: assert property (pwm_mode |=> $stable(compare_output))
        else $error("Compare output moved in a PWM mode.");

endmodule
`default_nettype wire

// ---- test/tcc_cnt_model.sv ----
// Counter unit stand-in that feeds the capture and compare block.
`timescale 1ns/1ps
`default_nettype none

module tcc_cnt_model (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Run request from the bench and load from the block
    input wire logic run,
    input wire logic counter_write,
    input wire logic [15:0] counter_wdata,
    // Counter outputs
    output logic [15:0] counter_value,
    output logic timer_tick
);
    // A CPU load wins over counting, so a load and a tick never mix.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            counter_value <= 16'h0000;
            timer_tick <= 1'b0;
        end else begin
            timer_tick <= run;
            if (counter_write) begin
                counter_value <= counter_wdata;
            end else if (timer_tick) begin
                counter_value <= counter_value + 16'h0001;
            end
        end
    end
endmodule

`default_nettype wire

// ---- test/test_timer16_capture_compare.sv ----
// Self-checking bench for the timer capture and compare block.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_consts.svh"

module test_timer16_capture_compare;
    logic clk, arst_n, cpu_wr, cpu_rd, run, buffer_load, counter_write, timer_tick;
    logic [2:0] cpu_loc;
    logic [7:0] cpu_wdata, cpu_rdata, d;
    logic [15:0] counter_value, counter_wdata, capture_register, compare_value_a, compare_value_b;
    logic [3:0] mode;
    logic comp_sel, filt_en, edge_sel, cap_ie, cap_clr, cap_ack, pin, comp_out;
    logic capture_flag, capture_irq, compare_top_a;
    logic [1:0] cmp_ie, act_a, act_b, force_stb, cmp_clr, cmp_ack;
    logic [1:0] compare_flag, compare_irq, compare_match, compare_output;
    int n;
    int err_total = 0;
    int tests_run = 0;
    int match_seen = 0;
    int top_seen = 0;

    tcc_top dut (
        .clk, .arst_n, .cpu_wr, .cpu_rd, .cpu_loc, .cpu_wdata, .cpu_rdata,
        .counter_value, .timer_tick, .buffer_load, .counter_write, .counter_wdata,
        .waveform_mode_select(mode), .comparator_capture_select(comp_sel),
        .capture_filter_enable(filt_en), .capture_edge_select(edge_sel),
        .capture_irq_enable(cap_ie), .compare_irq_enable(cmp_ie),
        .output_action_select_a(act_a), .output_action_select_b(act_b),
        .force_match_strobe(force_stb), .capture_flag_clear(cap_clr),
        .capture_irq_ack(cap_ack), .compare_flag_clear(cmp_clr), .compare_irq_ack(cmp_ack),
        .capture_input_pin(pin), .comparator_output(comp_out), .capture_flag, .capture_irq,
        .compare_flag, .compare_irq, .compare_match, .compare_output, .capture_register,
        .compare_value_a, .compare_value_b, .compare_top_a
    );

    tcc_cnt_model cnt (
        .clk, .arst_n, .run, .counter_write, .counter_wdata, .counter_value, .timer_tick
    );

    // Match pulses are combinational, so they are counted where they have settled.
    always @(negedge clk) begin
        match_seen <= match_seen + int'(compare_match[0] === 1'b1);
        top_seen <= top_seen + int'(compare_top_a === 1'b1);
    end

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // Drivers start on a rising edge; samplers end on a falling edge so outputs have settled.
    task automatic cpu_w(input logic [2:0] loc, input logic [7:0] v);
        @(posedge clk);
        cpu_wr <= 1'b1;
        cpu_loc <= loc;
        cpu_wdata <= v;
        @(posedge clk);
        cpu_wr <= 1'b0;
    endtask

    task automatic wr16(input logic [2:0] lo, input logic [15:0] v);
        cpu_w(lo + 3'h1, v[15:8]);
        cpu_w(lo, v[7:0]);
    endtask

    task automatic cpu_r(input logic [2:0] loc);
        @(posedge clk);
        cpu_rd <= 1'b1;
        cpu_loc <= loc;
        @(posedge clk);
        cpu_rd <= 1'b0;
        @(negedge clk);
        d = cpu_rdata;
    endtask

    task automatic pulse(input logic [5:0] sel);
        @(posedge clk) {cap_clr, cap_ack, cmp_ack, cmp_clr} <= sel;
        @(posedge clk) {cap_clr, cap_ack, cmp_ack, cmp_clr} <= 6'h00;
        @(negedge clk);
    endtask

    task automatic wflag(input bit cmp);
        n = 0;
        @(negedge clk);
        while ((cmp ? compare_flag[0] : capture_flag) !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic frc;
        @(posedge clk) force_stb <= 2'b10;
        @(posedge clk) force_stb <= 2'b00;
        @(negedge clk);
    endtask

    task automatic t_reset;
        chk(capture_register, 16'h0000);
        chk(compare_value_a | compare_value_b, 16'h0000);
        chk({13'h0000, capture_flag, compare_flag}, 16'h0000);
        cpu_r(`TCC_LOC_CAP_H);
        chk({8'h00, d}, 16'h0000);
    endtask

    task automatic t_capture;
        wr16(`TCC_LOC_CNT_L, 16'h1234);
        @(posedge clk) pin <= 1'b1;
        wflag(1'b0);
        chk(16'(n), 16'h0003);
        chk(capture_register, 16'h1234);
        chk({15'h0000, capture_irq}, 16'h0001);
        pulse(6'h10);
        chk({15'h0000, capture_flag}, 16'h0000);
        @(posedge clk) edge_sel <= 1'b0;
        pulse(6'h20);
        wr16(`TCC_LOC_CNT_L, 16'h5678);
        @(posedge clk) pin <= 1'b0;
        wflag(1'b0);
        chk(capture_register, 16'h5678);
        pulse(6'h20);
        chk({15'h0000, capture_flag}, 16'h0000);
        cpu_r(`TCC_LOC_CAP_L);
        chk({8'h00, d}, 16'h0078);
        cpu_r(`TCC_LOC_CAP_H);
        chk({8'h00, d}, 16'h0056);
        wr16(`TCC_LOC_CNT_L, 16'h9ABC);
        cpu_r(`TCC_LOC_CNT_L);
        cpu_r(`TCC_LOC_CAP_H);
        chk({8'h00, d}, 16'h009A);
    endtask

    task automatic t_filter;
        @(posedge clk) edge_sel <= 1'b1;
        filt_en <= 1'b1;
        repeat (8) @(posedge clk);
        pin <= 1'b1;
        wflag(1'b0);
        chk(16'(n), 16'h0007);
        pulse(6'h20);
        // Three low samples are one short of what the filter needs to pass a level.
        @(posedge clk) pin <= 1'b0;
        repeat (3) @(posedge clk);
        pin <= 1'b1;
        wflag(1'b0);
        chk({15'h0000, capture_flag}, 16'h0000);
        @(posedge clk) filt_en <= 1'b0;
    endtask

    task automatic t_source;
        @(posedge clk) comp_sel <= 1'b1;
        repeat (4) @(posedge clk);
        pulse(6'h20);
        @(posedge clk) pin <= 1'b0;
        repeat (4) @(posedge clk);
        pin <= 1'b1;
        wflag(1'b0);
        chk({15'h0000, capture_flag}, 16'h0000);
        @(posedge clk) comp_out <= 1'b1;
        wflag(1'b0);
        chk(16'(n), 16'h0003);
        @(posedge clk) comp_sel <= 1'b0;
        repeat (4) @(posedge clk);
        pulse(6'h20);
    endtask

    task automatic t_captop;
        @(posedge clk) mode <= `TCC_MODE_CTC_CAP;
        pin <= 1'b0;
        repeat (6) @(posedge clk);
        pin <= 1'b1;
        wflag(1'b0);
        chk({15'h0000, capture_flag}, 16'h0000);
        wr16(`TCC_LOC_CAP_L, 16'hABCD);
        @(negedge clk);
        chk(capture_register, 16'hABCD);
        @(posedge clk) mode <= `TCC_MODE_NORMAL;
        repeat (6) @(posedge clk);
        wr16(`TCC_LOC_CAP_L, 16'h1111);
        @(negedge clk);
        chk(capture_register, 16'hABCD);
    endtask

    task automatic t_cmp;
        @(posedge clk) mode <= 4'h1;
        wr16(`TCC_LOC_CMPB_L, 16'h1357);
        @(negedge clk);
        chk(compare_value_b, 16'h0000);
        wr16(`TCC_LOC_CMPA_L, 16'h2468);
        @(negedge clk);
        chk(compare_value_a, 16'h0000);
        cpu_r(`TCC_LOC_CAP_L);
        cpu_r(`TCC_LOC_CMPB_H);
        chk({8'h00, d}, 16'h0013);
        @(posedge clk) buffer_load <= 1'b1;
        @(posedge clk) buffer_load <= 1'b0;
        @(negedge clk);
        chk(compare_value_b, 16'h1357);
        chk(compare_value_a, 16'h2468);
        @(posedge clk) mode <= `TCC_MODE_NORMAL;
        wr16(`TCC_LOC_CMPA_L, 16'h0040);
        @(negedge clk);
        chk(compare_value_a, 16'h0040);
    endtask

    task automatic t_match;
        logic [5:0] sel [2] = '{6'h04, 6'h01};
        wr16(`TCC_LOC_CNT_L, 16'h0040);
        @(posedge clk) run <= 1'b1;
        @(posedge clk) run <= 1'b0;
        repeat (3) @(negedge clk);
        chk({14'h0000, compare_flag}, 16'h0000);
        foreach (sel[i]) begin
            wr16(`TCC_LOC_CNT_L, 16'h003E);
            @(posedge clk) run <= 1'b1;
            wflag(1'b1);
            chk({14'h0000, compare_irq}, 16'h0001);
            chk({15'h0000, compare_output[0]}, (i == 0) ? 16'h0001 : 16'h0000);
            @(posedge clk) run <= 1'b0;
            pulse(sel[i]);
            chk({14'h0000, compare_flag}, 16'h0000);
        end
        chk(16'(match_seen), 16'h0002);
        chk(16'(top_seen), 16'h0003);
    endtask

    task automatic t_force;
        @(posedge clk) mode <= 4'h1;
        act_b <= `TCC_ACT_SET;
        frc();
        chk({15'h0000, compare_output[1]}, 16'h0000);
        @(posedge clk) mode <= `TCC_MODE_NORMAL;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) act_b <= 2'(i);
            frc();
            chk({12'h000, compare_output, compare_flag}, (i % 2) ? 16'h0008 : 16'h0000);
        end
    endtask

    task automatic tally_and_finish;
        $display("Checks run %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        arst_n = 1'b0;
        {cpu_wr, cpu_rd, run, buffer_load, comp_sel, filt_en, pin, comp_out} = 8'h00;
        {cap_clr, cap_ack, cmp_ack, cmp_clr, force_stb} = 8'h00;
        {cpu_loc, cpu_wdata, mode} = 15'h0000;
        {edge_sel, cap_ie, cmp_ie, act_a, act_b} = 8'hD4;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        t_reset();
        t_capture();
        t_filter();
        t_source();
        t_captop();
        t_cmp();
        t_match();
        t_force();
        tally_and_finish();
    end

    // The whole sequence needs a few hundred cycles.
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
